// File: logic/gucs_status_bank.sv
// cyclic status holding-register bank with relay command gating
`timescale 1ns/1ps
module gucs_status_bank
    import gucs_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = GUCS_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // register request from the protocol engine
    input  wire logic                        req_valid,
    input  wire logic                        req_write,
    input  wire logic [15:0]                 req_addr,
    input  wire logic [15:0]                 req_wdata,
    // register answer
    output logic                             rsp_valid,
    output logic [15:0]                      rsp_rdata,
    output logic                             rsp_exc,
    output logic [7:0]                       rsp_code,
    // relay and horn switch command
    input  wire logic                        cmd_valid,
    input  wire logic [4:0]                  cmd_sel,
    input  wire logic                        cmd_on,
    output logic                             cmd_done,
    output logic                             cmd_exc,
    // unit state from the gas detection logic
    input  wire logic [GUCS_STATUS_BITS-1:0] unit_status,
    input  wire logic [GUCS_BASE_RELAYS-1:0] base_alarm_on,
    input  wire logic [GUCS_MOD_RELAYS-1:0]  mod_alarm_on,
    input  wire logic                        horn_alarm_on,
    // parameterisation
    input  wire logic [GUCS_BASE_RELAYS-1:0] base_closed_circuit,
    input  wire logic [GUCS_MOD_RELAYS-1:0]  mod_closed_circuit,
    input  wire logic [GUCS_BASE_RELAYS-1:0] base_bus_assigned,
    input  wire logic [GUCS_MOD_RELAYS-1:0]  mod_bus_assigned,
    input  wire logic                        horn_bus_assigned,
    // field gateway query toggle pin
    input  wire logic                        gw_query_toggle,
    // coil drives and link fault
    output logic [GUCS_BASE_RELAYS-1:0]      base_coil,
    output logic [GUCS_MOD_RELAYS-1:0]       mod_coil,
    output logic                             horn_drive,
    output logic                             link_timeout
);

    typedef struct packed {
        logic [15:0]                 sig;
        logic [GUCS_BASE_RELAYS-1:0] base_cmd;
        logic [GUCS_MOD_RELAYS-1:0]  mod_cmd;
        logic                        horn_cmd;
        logic [GUCS_BASE_RELAYS-1:0] base_coil;
        logic [GUCS_MOD_RELAYS-1:0]  mod_coil;
        logic                        horn_drv;
        logic                        rsp_valid;
        logic [15:0]                 rsp_rdata;
        logic                        rsp_exc;
        logic [7:0]                  rsp_code;
        logic                        cmd_done;
        logic                        cmd_exc;
        logic                        gw_last;
    } gucs_bank_t;

    gucs_bank_t st_r;
    gucs_bank_t st_nxt;

    logic                        gw_level;
    logic                        query_evt;
    logic [GUCS_BASE_RELAYS-1:0] base_logic;
    logic [GUCS_MOD_RELAYS-1:0]  mod_logic;
    logic                        horn_logic;
    logic                        cmd_ok;

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------
    function automatic logic gucs_mapped(input logic [15:0] a);
        return (a >= GUCS_ADDR_SIG) && (a <= GUCS_ADDR_HORN_ASG);
    endfunction : gucs_mapped

    function automatic logic gucs_is_ro(input logic [15:0] a);
        return gucs_mapped(a) && (a != GUCS_ADDR_SIG);
    endfunction : gucs_is_ro

    // ------------------------------------------------------------
    // gateway toggle pin and supervision
    // ------------------------------------------------------------
    gucs_pin_sync #(
        .W         (1)
    ) u_gw_sync (
        .mclk      (mclk),
        .rst       (rst),
        .pin_in    (gw_query_toggle),
        .level_out (gw_level)
    );

    // a gateway toggle or any register request counts as a poll
    assign query_evt = (gw_level != st_r.gw_last) || req_valid;

    gucs_link_timeout #(
        .LIMIT     (TIMEOUT_CYCLES)
    ) u_tmo (
        .mclk      (mclk),
        .rst       (rst),
        .query     (query_evt),
        .timeout   (link_timeout)
    );

    // ------------------------------------------------------------
    // logical state: local alarm setting or assigned bus command
    // ------------------------------------------------------------
    assign base_logic = base_alarm_on | (st_r.base_cmd & base_bus_assigned);
    assign mod_logic  = mod_alarm_on | (st_r.mod_cmd & mod_bus_assigned);
    assign horn_logic = horn_alarm_on | (st_r.horn_cmd & horn_bus_assigned);

    // command acceptance needs the matching assignment flag
    always_comb begin
        cmd_ok = 1'b0;
        if (cmd_sel < GUCS_SEL_MOD_FIRST) begin
            cmd_ok = base_bus_assigned[cmd_sel[2:0]];
        end else if (cmd_sel < GUCS_SEL_HORN) begin
            cmd_ok = mod_bus_assigned[4'(cmd_sel - GUCS_SEL_MOD_FIRST)];
        end else if (cmd_sel == GUCS_SEL_HORN) begin
            cmd_ok = horn_bus_assigned;
        end
    end

    // ------------------------------------------------------------
    // next state: register access, commands, coil drive
    // ------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        st_nxt.gw_last   = gw_level;
        st_nxt.rsp_valid = req_valid;
        st_nxt.rsp_exc   = 1'b0;
        st_nxt.rsp_code  = GUCS_EXC_NONE;
        st_nxt.cmd_done  = cmd_valid;
        st_nxt.cmd_exc   = 1'b0;

        // register bank; data is cleared so stale reads never leak
        if (req_valid) begin
            st_nxt.rsp_rdata = 16'h0000;
            if (!gucs_mapped(req_addr)) begin
                st_nxt.rsp_exc  = 1'b1;
                st_nxt.rsp_code = GUCS_EXC_ADDR;
            end else if (req_write) begin
                if (gucs_is_ro(req_addr)) begin
                    st_nxt.rsp_exc  = 1'b1;
                    st_nxt.rsp_code = GUCS_EXC_ADDR;
                end else begin
                    st_nxt.sig = req_wdata;
                end
            end else begin
                unique case (req_addr)
                    GUCS_ADDR_SIG: begin
                        st_nxt.rsp_rdata = st_r.sig;
                        st_nxt.sig       = st_r.sig - GUCS_SIG_STEP;
                    end
                    GUCS_ADDR_STATUS: begin
                        st_nxt.rsp_rdata = 16'(unit_status);
                    end
                    GUCS_ADDR_BASE_REL: begin
                        st_nxt.rsp_rdata = 16'(base_logic)
                            | (16'(st_r.base_coil) << GUCS_BASE_PHY_POS);
                    end
                    GUCS_ADDR_MOD_LOG: begin
                        st_nxt.rsp_rdata = mod_logic;
                    end
                    GUCS_ADDR_MOD_PHY: begin
                        st_nxt.rsp_rdata = st_r.mod_coil;
                    end
                    GUCS_ADDR_HORN: begin
                        st_nxt.rsp_rdata = 16'(horn_logic);
                    end
                    GUCS_ADDR_BASE_ASG: begin
                        st_nxt.rsp_rdata = 16'(base_bus_assigned);
                    end
                    GUCS_ADDR_MOD_ASG: begin
                        st_nxt.rsp_rdata = mod_bus_assigned;
                    end
                    GUCS_ADDR_HORN_ASG: begin
                        st_nxt.rsp_rdata = 16'(horn_bus_assigned);
                    end
                    default: begin
                        st_nxt.rsp_rdata = 16'h0000;
                    end
                endcase
            end
        end

        // switch commands; refused ones leave the state untouched
        if (cmd_valid) begin
            if (!cmd_ok) begin
                st_nxt.cmd_exc = 1'b1;
            end else if (cmd_sel < GUCS_SEL_MOD_FIRST) begin
                st_nxt.base_cmd[cmd_sel[2:0]] = cmd_on;
            end else if (cmd_sel < GUCS_SEL_HORN) begin
                st_nxt.mod_cmd[4'(cmd_sel - GUCS_SEL_MOD_FIRST)] = cmd_on;
            end else begin
                st_nxt.horn_cmd = cmd_on;
            end
        end

        // coil follows logical state, inverted for closed-circuit relays
        st_nxt.base_coil = base_logic ^ base_closed_circuit;
        st_nxt.mod_coil  = mod_logic ^ mod_closed_circuit;
        st_nxt.horn_drv  = horn_logic;
    end

    // a single register keeps the whole bank state coherent
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r     <= '0;
            st_r.sig <= GUCS_SIG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------
    assign rsp_valid  = st_r.rsp_valid;
    assign rsp_rdata  = st_r.rsp_rdata;
    assign rsp_exc    = st_r.rsp_exc;
    assign rsp_code   = st_r.rsp_code;
    assign cmd_done   = st_r.cmd_done;
    assign cmd_exc    = st_r.cmd_exc;
    assign base_coil  = st_r.base_coil;
    assign mod_coil   = st_r.mod_coil;
    assign horn_drive = st_r.horn_drv;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    wire rd_hit = req_valid && !req_write;

    AST_SIG_DEC: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && req_addr == GUCS_ADDR_SIG)
        |=> (rsp_rdata == $past(st_r.sig)) && (st_r.sig == $past(st_r.sig) - GUCS_SIG_STEP))
        else $error("signature not returned and decremented");
    AST_SIG_WR: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && req_write && req_addr == GUCS_ADDR_SIG)
        |=> !rsp_exc && st_r.sig == $past(req_wdata))
        else $error("signature write lost");
    AST_STATUS_MAP: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && req_addr == GUCS_ADDR_STATUS) |=> rsp_rdata == {11'h000, $past(unit_status)})
        else $error("status word mismatch");
    AST_BASE_MAP: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && req_addr == GUCS_ADDR_BASE_REL)
        |=> rsp_rdata[4:0] == $past(base_logic) && rsp_rdata[12:8] == $past(st_r.base_coil)
            && rsp_rdata[7:5] == 3'h0 && rsp_rdata[15:13] == 3'h0)
        else $error("base relay word mismatch");
    AST_HORN_ZERO: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && (req_addr == GUCS_ADDR_HORN || req_addr == GUCS_ADDR_HORN_ASG))
        |=> rsp_valid && rsp_rdata[15:1] == 15'h0000)
        else $error("horn word upper bits not zero");
    AST_ASG_MAP: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && req_addr == GUCS_ADDR_MOD_ASG) |=> rsp_rdata == $past(mod_bus_assigned))
        else $error("module assignment word mismatch");
    AST_CONTACT: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> mod_coil == ($past(mod_logic) ^ $past(mod_closed_circuit)))
        else $error("contact state does not follow logical state");
    AST_CMD_REFUSE: assert property (@(posedge mclk) disable iff (rst)
        (cmd_valid && !cmd_ok)
        |=> cmd_done && cmd_exc && $stable(st_r.base_cmd) && $stable(st_r.mod_cmd) && $stable(st_r.horn_cmd))
        else $error("unassigned command not refused");
    AST_RO_WRITE: assert property (@(posedge mclk) disable iff (rst)
        (req_valid && req_write && gucs_is_ro(req_addr))
        |=> rsp_exc && rsp_code == GUCS_EXC_ADDR && $stable(st_r.sig))
        else $error("read-only write not refused");
    AST_MODLOG_MAP: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && req_addr == GUCS_ADDR_MOD_LOG) |=> rsp_rdata == $past(mod_logic))
        else $error("module logical word mismatch");
    AST_MODPHY_MAP: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && req_addr == GUCS_ADDR_MOD_PHY) |=> rsp_rdata == $past(mod_coil))
        else $error("module contact word mismatch");
    AST_BASEASG_MAP: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && req_addr == GUCS_ADDR_BASE_ASG) |=> rsp_rdata == {11'h000, $past(base_bus_assigned)})
        else $error("base assignment word mismatch");
    AST_HORNASG_MAP: assert property (@(posedge mclk) disable iff (rst)
        (rd_hit && req_addr == GUCS_ADDR_HORN_ASG) |=> rsp_rdata == {15'h0000, $past(horn_bus_assigned)})
        else $error("horn assignment word mismatch");

    COV_SIG_READ: cover property (@(posedge mclk) disable iff (rst)
        rd_hit && req_addr == GUCS_ADDR_SIG ##2 rd_hit && req_addr == GUCS_ADDR_SIG);
    COV_CMD_OK: cover property (@(posedge mclk) disable iff (rst) cmd_valid && cmd_ok);
    COV_CMD_EXC: cover property (@(posedge mclk) disable iff (rst) cmd_valid && !cmd_ok);

endmodule : gucs_status_bank

// File: logic/gucs_pkg.sv
// package: register map, bit layout, exception codes and timing of the cyclic status bank
package gucs_pkg;

    // ------------------------------------------------------------
    // register addresses (16-bit holding registers)
    // ------------------------------------------------------------
    localparam logic [15:0] GUCS_ADDR_SIG       = 16'h0200;
    localparam logic [15:0] GUCS_ADDR_STATUS    = 16'h0201;
    localparam logic [15:0] GUCS_ADDR_BASE_REL  = 16'h0202;
    localparam logic [15:0] GUCS_ADDR_MOD_LOG   = 16'h0203;
    localparam logic [15:0] GUCS_ADDR_MOD_PHY   = 16'h0204;
    localparam logic [15:0] GUCS_ADDR_HORN      = 16'h0205;
    localparam logic [15:0] GUCS_ADDR_BASE_ASG  = 16'h0206;
    localparam logic [15:0] GUCS_ADDR_MOD_ASG   = 16'h0207;
    localparam logic [15:0] GUCS_ADDR_HORN_ASG  = 16'h0208;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int          GUCS_BASE_RELAYS    = 5;
    localparam int          GUCS_MOD_RELAYS     = 16;
    localparam int          GUCS_STATUS_BITS    = 5;
    localparam int          GUCS_BASE_PHY_POS   = 8;
    localparam logic [15:0] GUCS_SIG_RST        = 16'h0000;
    localparam logic [15:0] GUCS_SIG_STEP       = 16'h0001;

    // command selector: 0..4 base relays, 5..20 module relays, 21 horn
    localparam logic [4:0]  GUCS_SEL_MOD_FIRST  = 5'h05;
    localparam logic [4:0]  GUCS_SEL_HORN       = 5'h15;

    // ------------------------------------------------------------
    // exception codes returned to the master
    // ------------------------------------------------------------
    localparam logic [7:0]  GUCS_EXC_NONE       = 8'h00;
    localparam logic [7:0]  GUCS_EXC_FUNC       = 8'h01;
    localparam logic [7:0]  GUCS_EXC_ADDR       = 8'h02;

    // ------------------------------------------------------------
    // link supervision timing
    // ------------------------------------------------------------
    localparam longint      GUCS_CLK_HZ         = 25_000_000;
    localparam longint      GUCS_TIMEOUT_MS     = 3000;
    localparam int unsigned GUCS_TIMEOUT_CYCLES =
        int'((GUCS_TIMEOUT_MS * GUCS_CLK_HZ + 999) / 1000);
    localparam int          GUCS_TMO_W          = 27;

endpackage : gucs_pkg

// File: logic/gucs_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gucs_pin_sync
    import gucs_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // pin side
    input  wire logic [W-1:0] pin_in,
    // filtered level
    output logic      [W-1:0] level_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } gucs_sync_t;

    gucs_sync_t st_r;
    gucs_sync_t st_nxt;

    // ------------------------------------------------------------
    // shift chain; s1 feeds only s2 to keep metastability contained
    // ------------------------------------------------------------
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // a change counts once stages two and three agree
        if (st_r.s2 == st_r.s3) begin
            st_nxt.stable = st_r.s3;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.stable;

endmodule : gucs_pin_sync

// File: logic/gucs_link_timeout.sv
// poll supervision: flags the field link faulty when queries stop
`timescale 1ns/1ps
module gucs_link_timeout
    import gucs_pkg::*;
#(
    parameter int unsigned LIMIT = GUCS_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // query seen this cycle
    input  wire logic query,
    // link fault level
    output logic      timeout
);

    typedef struct packed {
        logic [GUCS_TMO_W-1:0] cnt;
        logic                  tmo;
    } gucs_tmo_t;

    gucs_tmo_t st_r;
    gucs_tmo_t st_nxt;

    localparam logic [GUCS_TMO_W-1:0] LAST = GUCS_TMO_W'(LIMIT - 1);

    // ------------------------------------------------------------
    // each query restarts the interval; count saturates at LIMIT - 1
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (query) begin
            st_nxt.cnt = '0;
            st_nxt.tmo = 1'b0;
        end else if (st_r.cnt == LAST) begin
            st_nxt.tmo = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + GUCS_TMO_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign timeout = st_r.tmo;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_TMO_SET: assert property (@(posedge mclk) disable iff (rst)
        (st_r.cnt == LAST && !query) |=> timeout)
        else $error("timeout not raised at end of interval");
    AST_TMO_EARLY: assert property (@(posedge mclk) disable iff (rst)
        (query ##1 !query [*2]) |-> !timeout)
        else $error("timeout raised right after a query");
    COV_TMO_RISE: cover property (@(posedge mclk) disable iff (rst) $rose(timeout));

endmodule : gucs_link_timeout

// File: testbench/gucs_master_model.sv
// remote master model: register polls and gateway query toggles
`timescale 1ns/1ps
module gucs_master_model (
    // clock
    input  wire logic        mclk,
    // request side
    output logic             req_valid,
    output logic             req_write,
    output logic [15:0]      req_addr,
    output logic [15:0]      req_wdata,
    output logic             gw_query_toggle,
    // answer side
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_rdata,
    input  wire logic        rsp_exc,
    input  wire logic [7:0]  rsp_code
);
    // idle bus at time zero
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
        gw_query_toggle = 1'b0;
    end

    // one request; each call is a fresh poll, so repeated calls keep the link alive
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic v, output logic [15:0] q, output logic e, output logic [7:0] c);
        @(posedge mclk);
        #1 {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        @(posedge mclk);
        // taken at this edge; the answer pulse stands only until the next edge
        // released lines must not keep the old value
        #1 {req_valid, req_write, req_addr, req_wdata} = {2'b00, ~a, ~d};
        {v, q, e, c} = {rsp_valid, rsp_rdata, rsp_exc, rsp_code};
    endtask : xfer

    // gateway query seen as a pin toggle
    task automatic poke();
        @(posedge mclk);
        #1 gw_query_toggle = ~gw_query_toggle;
    endtask : poke
endmodule : gucs_master_model

// File: testbench/tb.sv
// self-checking bench for the cyclic status bank
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("ERROR %0t got %h expected %h", $time, a, e); end end
module tb;
    import gucs_pkg::*;
    logic        mclk, rst, rv, rw, re, cv, con, cd, ce, hd, lt, gwt, v, e;
    logic [15:0] ra, rwd, rd, q;
    logic [7:0]  rc, c;
    logic [4:0]  cs, bc;
    logic [15:0] mc, ma, mcc, mba;
    logic [4:0]  us, ba, bcc, bba;
    logic        ha, hba;
    int          error_cnt = 0, checks_done = 0, cyc = 0;
    logic [15:0] row_a [8] = '{16'h0201, 16'h0202, 16'h0203, 16'h0204, 16'h0205, 16'h0206, 16'h0207, 16'h0208};
    logic [15:0] row_q [8] = '{16'h0015, 16'h090A, 16'hA5C3, 16'hAACC, 16'h0000, 16'h0011, 16'h8001, 16'h0001};

    gucs_status_bank #(.TIMEOUT_CYCLES(50)) u_dut (.mclk(mclk), .rst(rst), .req_valid(rv), .req_write(rw),
        .req_addr(ra), .req_wdata(rwd), .rsp_valid(v), .rsp_rdata(rd), .rsp_exc(re), .rsp_code(rc),
        .cmd_valid(cv), .cmd_sel(cs), .cmd_on(con), .cmd_done(cd), .cmd_exc(ce), .unit_status(us),
        .base_alarm_on(ba), .mod_alarm_on(ma), .horn_alarm_on(ha), .base_closed_circuit(bcc),
        .mod_closed_circuit(mcc), .base_bus_assigned(bba), .mod_bus_assigned(mba),
        .horn_bus_assigned(hba), .gw_query_toggle(gwt), .base_coil(bc), .mod_coil(mc), .horn_drive(hd),
        .link_timeout(lt));
    gucs_master_model u_mst (.mclk(mclk), .req_valid(rv), .req_write(rw), .req_addr(ra), .req_wdata(rwd),
        .gw_query_toggle(gwt), .rsp_valid(v), .rsp_rdata(rd), .rsp_exc(re), .rsp_code(rc));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // hang guard: the tests need about 140 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // one register access and full answer check
    task automatic acc(input logic w, input logic [15:0] a, d, eq, input logic ee, input logic [7:0] ec);
        logic       vv, xe;
        logic [15:0] xq;
        logic [7:0] xc;
        u_mst.xfer(w, a, d, vv, xq, xe, xc);
        `CHK(vv, 1'b1)
        `CHK(xq, eq)
        `CHK(xe, ee)
        `CHK(xc, ec)
    endtask : acc

    // one switch command; answer registered at the same edge that takes it
    // the answer pulse stands only for the cycle after the taking edge
    task automatic cmd(input logic [4:0] s, input logic ex, input logic on);
        @(posedge mclk);
        #1 {cv, cs, con} = {1'b1, s, on};
        @(posedge mclk);
        #1 cv = 1'b0;
        `CHK({cd, ce}, {1'b1, ex})
    endtask : cmd

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // main sequence
    initial begin
        {rst, cv, cs, con} = {1'b1, 1'b0, 5'h00, 1'b0};
        {us, ba, ma, ha} = {5'h15, 5'h0A, 16'hA5C3, 1'b0};
        {bcc, mcc, bba, mba, hba} = {5'h03, 16'h0F0F, 5'h11, 16'h8001, 1'b1};
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        `CHK({v, re, lt}, 3'b000)
        acc(1'b0, GUCS_ADDR_SIG, 16'h0000, 16'h0000, 1'b0, GUCS_EXC_NONE);
        acc(1'b0, GUCS_ADDR_SIG, 16'h0000, 16'hFFFF, 1'b0, GUCS_EXC_NONE);
        $display("test reset done");
        for (int i = 0; i < 8; i++) acc(1'b0, row_a[i], 16'h0000, row_q[i], 1'b0, GUCS_EXC_NONE);
        $display("test map done");
        acc(1'b1, GUCS_ADDR_SIG, 16'h1234, 16'h0000, 1'b0, GUCS_EXC_NONE);
        acc(1'b0, GUCS_ADDR_SIG, 16'h0000, 16'h1234, 1'b0, GUCS_EXC_NONE);
        acc(1'b0, GUCS_ADDR_SIG, 16'h0000, 16'h1233, 1'b0, GUCS_EXC_NONE);
        acc(1'b1, GUCS_ADDR_STATUS, 16'hFFFF, 16'h0000, 1'b1, GUCS_EXC_ADDR);
        acc(1'b0, GUCS_ADDR_STATUS, 16'h0000, 16'h0015, 1'b0, GUCS_EXC_NONE);
        acc(1'b0, 16'h0209, 16'h0000, 16'h0000, 1'b1, GUCS_EXC_ADDR);
        $display("test signature done");
        cmd(5'h01, 1'b1, 1'b1);
        cmd(5'h06, 1'b1, 1'b1);
        cmd(5'h16, 1'b1, 1'b1);
        cmd(5'h04, 1'b0, 1'b1);
        cmd(GUCS_SEL_HORN, 1'b0, 1'b1);
        repeat (2) @(posedge mclk);
        #1 `CHK({bc, hd}, {5'h19, 1'b1})
        acc(1'b0, GUCS_ADDR_BASE_REL, 16'h0000, 16'h191A, 1'b0, GUCS_EXC_NONE);
        acc(1'b0, GUCS_ADDR_HORN, 16'h0000, 16'h0001, 1'b0, GUCS_EXC_NONE);
        // relay 5 off, module relay 16 on, then working current and horn unassigned
        cmd(5'h04, 1'b0, 1'b0);
        cmd(5'h14, 1'b0, 1'b1);
        {ma, mcc, hba} = {16'h0000, 16'h0000, 1'b0};
        repeat (2) @(posedge mclk);
        #1 `CHK({bc, hd, mc}, {5'h09, 1'b0, 16'h8000})
        acc(1'b0, GUCS_ADDR_MOD_LOG, 16'h0000, 16'h8000, 1'b0, GUCS_EXC_NONE);
        acc(1'b0, GUCS_ADDR_HORN_ASG, 16'h0000, 16'h0000, 1'b0, GUCS_EXC_NONE);
        $display("test command done");
        // silence from the master: link must stay good, then fail
        repeat (40) @(posedge mclk);
        #1 `CHK(lt, 1'b0)
        repeat (20) @(posedge mclk);
        #1 `CHK(lt, 1'b1)
        u_mst.poke();
        repeat (8) @(posedge mclk);
        #1 `CHK(lt, 1'b0)
        $display("test timeout done");
        // reset in mid-run: outputs and signature return to their reset values
        @(posedge mclk);
        #1 rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        `CHK({v, re, lt, bc, mc}, 24'h000000)
        acc(1'b0, GUCS_ADDR_SIG, 16'h0000, GUCS_SIG_RST, 1'b0, GUCS_EXC_NONE);
        $display("test mid reset done");
        print_verdict();
    end
endmodule : tb
